// *** rtl/aofr_params.svh ***
// Constants for the output buffer readback block
// Contract
// [R01] Level select sets depth: off, 2 to 14
// [R02] Pulse batch ready when depth readings stored
// [R03] Oldest reading first, advance per strobe fall
// [R04] Host releases reset, then toggles read strobe
// [R05] Host reads exactly depth readings per batch
// [R06] Skipped readback stretches batch period to 128
// [R07] Wrong read count may stall batch ready
// [R08] Reset plus strobe clears buffer and filter
// [R09] Read strobe acts regardless of chip select
// [R10] Host may change depth then reset
// [R11] Depth change between first and last read
// [R12] New depth applies at once with period
// [R13] Host allows readout time before shrinking depth
// [R14] Power down low shuts down all circuitry
// [R15] Unconnected power down pin defaults high
// [R16] Host stops clock during power down
// [R17] Host resets after power down when buffered
// [R18] Host waits reference start and 100 batches
// [R19] Double rate picks ratio 4, else 8
// [R20] All sixteen data bits stay driven
// [R21] Host waits 13 batches in double rate
// [R22] Unconnected double rate pin defaults low
// [R23] Host may tie chip select low permanently
`ifndef AOFR_PARAMS_SVH
`define AOFR_PARAMS_SVH
`define AOFR_LEVEL_OFF      3'h0
`define AOFR_OSR_NORMAL     3'h7
`define AOFR_OSR_DOUBLE     3'h3
`define AOFR_SKIP_PERIOD    8'h80
`define AOFR_MAX_DEPTH      14
`define AOFR_DATA_W         16
`define AOFR_PIN_RST        7'h77
`endif

// *** rtl/aofr_pkg.sv ***
// Types shared by the output buffer readback block
package aofr_pkg;
	typedef struct packed {
		logic       rd_n;
		logic       cs_n;
		logic       pd_n;
		logic       dbl;
		logic [2:0] lev;
	} aofr_pins_t;

	typedef enum logic [1:0] {
		AOFR_ARM   = 2'h0,
		AOFR_RUN   = 2'h1,
		AOFR_STUCK = 2'h3,
		AOFR_OFF   = 2'h2
	} aofr_state_t;
endpackage

// *** rtl/aofr_sync.sv ***
// Two-flop synchroniser with a constant reset value per bit
`timescale 1ns/100ps
module aofr_sync #(
	parameter int         W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= RST_VAL;
			q        <= RST_VAL;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // aofr_sync

// *** rtl/aofr_top.sv ***
// Output buffer, readback and mode logic of the converter
`timescale 1ns/100ps
`include "aofr_params.svh"
module aofr_top #(
	parameter int MAX_DEPTH = `AOFR_MAX_DEPTH,
	parameter int DATA_W    = `AOFR_DATA_W
) (
	// Clock and reset
	input  wire logic              CLK,
	input  wire logic              RST_N,
	// Host read pins
	input  wire logic              RD_N,
	input  wire logic              CS_N,
	// Mode pins
	input  wire logic [2:0]        BUFFER_DEPTH_SEL,
	input  wire logic              POWER_DOWN_N,
	input  wire logic              DOUBLE_RATE_SEL,
	// Filter side
	input  wire logic [DATA_W-1:0] FILTER_DATA,
	output logic                   DECIM_TICK,
	output logic                   FILTER_CLEAR,
	output logic                   SHUTDOWN,
	// Host data side
	output logic [DATA_W-1:0]      DOUT,
	output logic                   DOUT_OE_N,
	output logic                   BATCH_READY_N
);
	if (MAX_DEPTH != `AOFR_MAX_DEPTH || DATA_W != `AOFR_DATA_W) begin : g_chk
		$error("aofr_top: depth and width are fixed by the level select coding");
	end

	aofr_pkg::aofr_pins_t pins;
	aofr_pkg::aofr_pins_t pins_raw;
	aofr_pkg::aofr_state_t state_reg;

	logic [DATA_W-1:0] col_mem [MAX_DEPTH];
	logic [DATA_W-1:0] rd_mem  [MAX_DEPTH];
	logic [2:0]        phase_reg;
	logic [2:0]        osr_last;
	logic              tick;
	logic              rd_prev_reg;
	logic              rd_fall;
	logic              rd_rise;
	logic [3:0]        depth;
	logic              enabled;
	logic [3:0]        col_cnt_reg;
	logic [3:0]        rd_idx_reg;
	logic [3:0]        reads_reg;
	logic [3:0]        batch_depth_reg;
	logic              first_reg;
	logic              pend_reg;
	logic [7:0]        since_reg;
	logic              batch_done;
	logic              skipped;
	logic              miscount;
	logic              copy_go;
	logic              pulse_now;

	assign pins_raw = '{rd_n: RD_N, cs_n: CS_N, pd_n: POWER_DOWN_N,
	                    dbl: DOUBLE_RATE_SEL, lev: BUFFER_DEPTH_SEL};

	// Reset values: strobe idle, deselected, pull-up on power down, pull-down on double rate,
	// level nonzero so arming waits until the live pins have come through
	aofr_sync #(
		.W       (7),
		.RST_VAL (`AOFR_PIN_RST)
	) u_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.d     (pins_raw),
		.q     (pins)
	); // [R15] [R22]

	assign depth      = {pins.lev, 1'b0}; // [R01]
	assign enabled    = pins.lev != `AOFR_LEVEL_OFF; // [R01]
	assign osr_last   = pins.dbl ? `AOFR_OSR_DOUBLE : `AOFR_OSR_NORMAL; // [R19]
	assign tick       = (state_reg == aofr_pkg::AOFR_RUN) && (phase_reg >= osr_last);
	assign rd_fall    = rd_prev_reg && !pins.rd_n;
	assign rd_rise    = !rd_prev_reg && pins.rd_n;
	// Depth read live so a synchronised change acts at once
	assign batch_done = tick && enabled && (col_cnt_reg + 4'h1 >= depth); // [R12]
	assign skipped    = !first_reg && (reads_reg == 4'h0); // [R06]
	assign miscount   = !first_reg && !skipped && (reads_reg != batch_depth_reg); // [R07]
	assign copy_go    = batch_done && !miscount;
	assign pulse_now  = (copy_go && !skipped) || (pend_reg && since_reg >= `AOFR_SKIP_PERIOD - 8'h01);

	// Decimation phase
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			phase_reg  <= 3'h0;
			DECIM_TICK <= 1'b0;
		end else begin
			if (state_reg != aofr_pkg::AOFR_RUN || tick) begin
				phase_reg <= 3'h0;
			end else begin
				phase_reg <= phase_reg + 3'h1; // [R19]
			end
			DECIM_TICK <= tick;
		end
	end

	// Read strobe edge history
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_prev_reg <= 1'b1;
		end else begin
			rd_prev_reg <= pins.rd_n;
		end
	end

	// Arming, running, stall and power down
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg    <= aofr_pkg::AOFR_ARM;
			FILTER_CLEAR <= 1'b0;
			SHUTDOWN     <= 1'b0;
		end else begin
			FILTER_CLEAR <= 1'b0;
			SHUTDOWN     <= !pins.pd_n; // [R14]
			if (!pins.pd_n) begin
				state_reg <= aofr_pkg::AOFR_OFF; // [R14]
			end else begin
				case (state_reg)
					aofr_pkg::AOFR_ARM: begin
						if (!enabled) begin
							state_reg <= aofr_pkg::AOFR_RUN;
						end else if (rd_rise) begin
							state_reg    <= aofr_pkg::AOFR_RUN; // [R08]
							FILTER_CLEAR <= 1'b1; // [R08]
						end
					end
					aofr_pkg::AOFR_RUN: begin
						if (batch_done && miscount) begin
							state_reg <= aofr_pkg::AOFR_STUCK; // [R07]
						end
					end
					aofr_pkg::AOFR_STUCK: begin
						state_reg <= aofr_pkg::AOFR_STUCK; // [R07]
					end
					aofr_pkg::AOFR_OFF: begin
						state_reg <= aofr_pkg::AOFR_ARM;
					end
					default: begin
						state_reg <= aofr_pkg::AOFR_ARM;
					end
				endcase
			end
		end
	end

	// Collect readings of the current batch
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			col_cnt_reg <= 4'h0;
		end else if (state_reg != aofr_pkg::AOFR_RUN) begin
			col_cnt_reg <= 4'h0; // [R08]
		end else if (batch_done) begin
			col_cnt_reg <= 4'h0;
		end else if (tick && enabled) begin
			col_cnt_reg <= col_cnt_reg + 4'h1;
		end
	end

	always_ff @(posedge CLK) begin
		if (tick && enabled) begin
			col_mem[col_cnt_reg] <= FILTER_DATA;
		end
	end

	// Hand a finished batch to the read bank
	always_ff @(posedge CLK) begin
		if (copy_go) begin
			for (int i = 0; i < MAX_DEPTH; i++) begin
				rd_mem[i] <= (i == int'(col_cnt_reg)) ? FILTER_DATA : col_mem[i];
			end
		end
	end

	// Batch bookkeeping and skip handling
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			first_reg       <= 1'b1;
			pend_reg        <= 1'b0;
			since_reg       <= 8'h00;
			batch_depth_reg <= 4'h0;
		end else if (state_reg != aofr_pkg::AOFR_RUN) begin
			first_reg <= 1'b1; // [R08]
			pend_reg  <= 1'b0;
			since_reg <= 8'h00;
		end else begin
			if (pulse_now) begin
				since_reg <= 8'h00;
			end else if (since_reg != 8'hFF) begin
				since_reg <= since_reg + 8'h01;
			end
			if (copy_go) begin
				first_reg       <= 1'b0;
				batch_depth_reg <= depth; // [R12]
			end
			if (copy_go && skipped && !pulse_now) begin
				pend_reg <= 1'b1; // [R06]
			end else if (pulse_now) begin
				pend_reg <= 1'b0;
			end
		end
	end

	// Read pointer and count of reads since the last batch
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_idx_reg <= 4'h0;
			reads_reg  <= 4'h0;
		end else if (state_reg != aofr_pkg::AOFR_RUN || copy_go) begin
			rd_idx_reg <= 4'h0;
			reads_reg  <= 4'h0;
		end else if (rd_fall && enabled) begin
			rd_idx_reg <= (rd_idx_reg < 4'(MAX_DEPTH - 1)) ? rd_idx_reg + 4'h1 : rd_idx_reg; // [R03] [R09]
			reads_reg  <= (reads_reg != 4'hF) ? reads_reg + 4'h1 : reads_reg;
		end
	end

	// Data pins: all sixteen bits in both rates
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			DOUT      <= '0;
			DOUT_OE_N <= 1'b1;
		end else begin
			DOUT_OE_N <= pins.cs_n || !pins.pd_n; // [R14]
			if (state_reg != aofr_pkg::AOFR_RUN) begin
				DOUT <= '0;
			end else if (!enabled && tick) begin
				DOUT <= FILTER_DATA; // [R20]
			end else if (enabled && rd_fall) begin
				DOUT <= rd_mem[rd_idx_reg]; // [R03] [R20]
			end
		end
	end

	// Batch ready: high for one clock per batch, high in reset
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			BATCH_READY_N <= 1'b1; // [R04]
		end else if (state_reg != aofr_pkg::AOFR_RUN) begin
			BATCH_READY_N <= 1'b0; // [R07]
		end else if (!enabled) begin
			BATCH_READY_N <= tick;
		end else begin
			BATCH_READY_N <= pulse_now; // [R02] [R06]
		end
	end
endmodule // aofr_top

// *** testbench/aofr_props_properties.sv ***
// Pin-level assertions for the readback block
`timescale 1ns/100ps
module aofr_props #(
	parameter int MAX_DEPTH = 14,
	parameter int DATA_W    = 16
) (
	// Watched pins
	input wire logic              CLK,
	input wire logic              RST_N,
	input wire logic              RD_N,
	input wire logic              CS_N,
	input wire logic              POWER_DOWN_N,
	input wire logic              DECIM_TICK,
	input wire logic              FILTER_CLEAR,
	input wire logic              SHUTDOWN,
	input wire logic [DATA_W-1:0] DOUT,
	input wire logic              DOUT_OE_N,
	input wire logic              BATCH_READY_N
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	property p_tick; DECIM_TICK |=> !DECIM_TICK [*3]; endproperty
	a_tick: assert property (p_tick) else $error("tick spacing short");
	property p_rdy; $rose(BATCH_READY_N) |=> !BATCH_READY_N; endproperty
	a_rdy: assert property (p_rdy) else $error("ready pulse too long");
	property p_clr; FILTER_CLEAR |=> !FILTER_CLEAR; endproperty
	a_clr: assert property (p_clr) else $error("clear pulse too long");
	property p_clr_rd; FILTER_CLEAR |-> $past(RD_N, 3); endproperty
	a_clr_rd: assert property (p_clr_rd) else $error("clear without strobe rise");
	property p_shut_on; !POWER_DOWN_N [*5] |-> SHUTDOWN; endproperty
	a_shut_on: assert property (p_shut_on) else $error("no shutdown");
	property p_shut_off; POWER_DOWN_N [*5] |-> !SHUTDOWN; endproperty
	a_shut_off: assert property (p_shut_off) else $error("stuck in shutdown");
	property p_oe_pd; SHUTDOWN |-> DOUT_OE_N; endproperty
	a_oe_pd: assert property (p_oe_pd) else $error("driving while shut down");
	property p_oe_cs; CS_N [*5] |-> DOUT_OE_N; endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("driving while deselected");
	property p_oe_on; (!CS_N && !SHUTDOWN) [*5] |-> !DOUT_OE_N; endproperty
	a_oe_on: assert property (p_oe_on) else $error("not driving when selected");
	property p_dout0; SHUTDOWN [*2] |-> DOUT == '0; endproperty
	a_dout0: assert property (p_dout0) else $error("data kept in shutdown");
endmodule // aofr_props

bind aofr_top aofr_props #(.MAX_DEPTH(MAX_DEPTH), .DATA_W(DATA_W)) u_prop (
	.CLK(CLK), .RST_N(RST_N), .RD_N(RD_N), .CS_N(CS_N), .POWER_DOWN_N(POWER_DOWN_N),
	.DECIM_TICK(DECIM_TICK), .FILTER_CLEAR(FILTER_CLEAR), .SHUTDOWN(SHUTDOWN), .DOUT(DOUT),
	.DOUT_OE_N(DOUT_OE_N), .BATCH_READY_N(BATCH_READY_N));

// *** testbench/aofr_filter_model.sv ***
// Filter output model feeding the readback block
`timescale 1ns/100ps
module aofr_filter_model (
	// Clock, reset and tick
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        clear,
	// Filter word
	output logic      [15:0] data
);
	// One new word per tick, so stored readings count up by one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			data <= 16'h0100;
		else if (clear)
			data <= 16'h0100;
		else if (tick)
			data <= data + 16'h0001;
	end
endmodule // aofr_filter_model

// *** testbench/tb_top.sv ***
// Testbench for the output buffer readback block
`timescale 1ns/100ps
module tb_top;
	logic        clk = 0, rst_n = 0, rd_n = 1, cs_n = 0, pd_n = 1, dbl = 0;
	logic [2:0]  lev = 0;
	logic [15:0] fdat, dout, prv;
	logic        tick, clr, shut, oe_n, rdy_n;
	int          cyc = 0, t_last = 0, per = 0, n_fail = 0, tests_run = 0;
	bit          got, clr_seen, clk_run = 1;
	always #4 clk = clk_run ? ~clk : clk;
	aofr_top dut_u (.CLK(clk), .RST_N(rst_n), .RD_N(rd_n), .CS_N(cs_n), .BUFFER_DEPTH_SEL(lev),
		.POWER_DOWN_N(pd_n), .DOUBLE_RATE_SEL(dbl), .FILTER_DATA(fdat), .DECIM_TICK(tick),
		.FILTER_CLEAR(clr), .SHUTDOWN(shut), .DOUT(dout), .DOUT_OE_N(oe_n), .BATCH_READY_N(rdy_n));
	aofr_filter_model flt_u (.clk(clk), .rst_n(rst_n), .tick(tick), .clear(clr), .data(fdat));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (clr)
			clr_seen <= 1;
		if (cyc == 30000) begin
			n_fail++;
			test_done;
		end
	end
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic rd_word(output logic [15:0] w);
		rd_n = 0;
		repeat (5) @(negedge clk);
		w = dout;
		rd_n = 1;
		repeat (2) @(negedge clk);
	endtask
	task automatic do_rst;
		rst_n = 0;
		repeat (3) @(negedge clk);
		@(posedge clk) rst_n <= 1;
		repeat (4) @(negedge clk);
		if (lev != 0)
			rd_word(prv);
		repeat (4) @(negedge clk);
	endtask
	task automatic wait_rdy(int lim);
		got = 0;
		for (int i = 0; i < lim && !got; i++) begin
			@(negedge clk);
			if (rdy_n === 1'b1) begin
				got = 1;
				per = cyc - t_last;
				t_last = cyc;
			end
		end
		if (got)
			@(negedge clk);
	endtask
	task automatic rd_batch(int n);
		logic [15:0] w;
		rd_word(prv);
		for (int i = 1; i < n; i++) begin
			rd_word(w);
			chk("dout", w, 16'(prv + 16'h1));
			prv = w;
		end
	endtask
	task automatic t_rate;
		lev = 0;
		do_rst;
		wait_rdy(50);
		wait_rdy(50);
		chk("per x8", per, 8);
		chk("dout x8", dout, 16'(fdat - 16'h1));
		dbl = 1;
		repeat (13)
			wait_rdy(50);
		wait_rdy(50);
		chk("per x4", per, 4);
		chk("dout x4", dout, 16'(fdat - 16'h1));
		dbl = 0;
		$display("rate test done");
	endtask
	task automatic t_level(logic [2:0] lv);
		lev = lv;
		do_rst;
		wait_rdy(300);
		rd_batch(2 * lv);
		wait_rdy(300);
		chk("per", per, 16 * lv);
		wait_rdy(300);
		chk("skip per", per, 128);
		$display("level test done");
	endtask
	task automatic t_stall;
		lev = 2;
		do_rst;
		wait_rdy(300);
		rd_batch(4);
		wait_rdy(300);
		rd_batch(3);
		wait_rdy(400);
		chk("stalled", got, 0);
		clr_seen = 0;
		do_rst;
		chk("clear", clr_seen, 1);
		wait_rdy(300);
		chk("recovered", got, 1);
		$display("stall test done");
	endtask
	task automatic t_change;
		lev = 2;
		do_rst;
		wait_rdy(300);
		rd_batch(4);
		wait_rdy(300);
		cs_n = 1;
		rd_word(prv);
		lev = 4;
		chk("oe off", oe_n, 1);
		for (int i = 0; i < 3; i++)
			rd_word(prv);
		wait_rdy(300);
		chk("new per", per, 64);
		cs_n = 0;
		$display("depth change test done");
	endtask
	task automatic t_pd;
		pd_n = 0;
		repeat (8) @(negedge clk);
		chk("shut", shut, 1);
		chk("oe pd", oe_n, 1);
		clk_run = 0;
		#78;
		clk_run = 1;
		@(negedge clk);
		pd_n = 1;
		repeat (6) @(negedge clk);
		chk("awake", shut, 0);
		do_rst;
		repeat (100)
			wait_rdy(300);
		chk("resumed", got, 1);
		rd_batch(8);
		$display("power down test done");
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		t_rate;
		for (int l = 1; l < 8; l++)
			t_level(3'(l));
		t_stall;
		t_change;
		t_pd;
		test_done;
	end
endmodule // tb_top
